// ---- logic/aag_pkg.sv ----
// Constants and carrier types for the auto acknowledgement block.
// Assumes a single 20 MHz clock and an active-low asynchronous reset.
// How it works
// - Repetition 64: count picks 64..512 preamble.
// - Repetition 1024: count picks 1024..2048 preamble.
// - Repetition 4096 in standard mode gives 4096 preamble.
// - Extended mode: count alone picks 16..4096.
// - Accumulation stops at 16-bit tap magnitude.
// - Chosen preamble at most one step longer.
// - Delimiter loaded only on host transmit.
// - Start plus off loads delimiter, no radiation.
// - Auto re-enable returns to receive after ack.
// - Turnaround delay from configurable input, scaled by TIM_SCALE.
// - Frame-pending bit copies configuration bit.
// - Requested flag sets with checksum-good flag.
// - Stale requested flag sends no acknowledgement.
// - Ack needs filtering, auto-ack, pass, request.
// - Send five-octet acknowledgement at reception end.
`default_nettype none

package aag_pkg;

  // ------------------------------------------------------------
  // Field widths and encodings
  // ------------------------------------------------------------
  localparam int PACC_W = 12;
  localparam int PLEN_W = 13;
  localparam int TIM_W  = 8;
  localparam int TAP_W  = 16;

  typedef enum logic [1:0] {
    AAG_PSR_64, AAG_PSR_1024, AAG_PSR_4096, AAG_PSR_RSVD
  } aag_psr_t;

  localparam logic [PLEN_W-1:0] PL_16   = 13'h0010;
  localparam logic [PLEN_W-1:0] PL_32   = 13'h0020;
  localparam logic [PLEN_W-1:0] PL_64   = 13'h0040;
  localparam logic [PLEN_W-1:0] PL_128  = 13'h0080;
  localparam logic [PLEN_W-1:0] PL_256  = 13'h0100;
  localparam logic [PLEN_W-1:0] PL_512  = 13'h0200;
  localparam logic [PLEN_W-1:0] PL_1024 = 13'h0400;
  localparam logic [PLEN_W-1:0] PL_1536 = 13'h0600;
  localparam logic [PLEN_W-1:0] PL_2048 = 13'h0800;
  localparam logic [PLEN_W-1:0] PL_4096 = 13'h1000;

  localparam logic [PACC_W-1:0] PACC_MAX = 12'hFFF;
  localparam logic [TAP_W-1:0]  TAP_LIMIT = 16'h8000;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_NS         = 50;
  localparam int SYMBOL_NS      = 1000;
  localparam int SYM_CYC        = (SYMBOL_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACK_OCTETS     = 5;
  localparam int OCTET_CYC      = 8;
  localparam int ACK_TX_CYC     = ACK_OCTETS * OCTET_CYC;
  localparam logic [TIM_W-1:0] TIM_RESET = 8'h0C;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic frame_filter_en;
    logic auto_ack_enable;
    logic rx_auto_reenable;
    logic ack_pending_value;
    logic ext_frame_mode;
  } aag_cfg_t;

  typedef struct packed {
    logic              rx_end;
    logic              crc_good;
    logic              filter_pass;
    logic              data_or_cmd;
    logic              ack_req_bit;
    aag_psr_t          rx_preamble_symbol_rep;
    logic [PACC_W-1:0] preamble_accum_count;
  } aag_rx_t;

  typedef enum logic [2:0] {
    AAG_IDLE, AAG_RX, AAG_TURN, AAG_TX, AAG_SFD_INIT
  } aag_state_t;

endpackage

`default_nettype wire

// ---- logic/aag_pacc.sv ----
// Preamble accumulation counter with tap saturation stop.
// Assumes per-symbol strobe and tap magnitude from the correlator.
`default_nettype none

module aag_pacc
  import aag_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // Accumulator control
  input  wire logic              acc_clear,
  input  wire logic              acc_symbol,
  input  wire logic [TAP_W-1:0]  tap_peak,
  output logic      [PACC_W-1:0] count_r,
  output logic                   saturated_r
);

  // ----------------------------------------------------------
  // Counting
  // ----------------------------------------------------------
  wire logic tap_full = (tap_peak >= TAP_LIMIT);
  wire logic step     = acc_symbol && !saturated_r && count_r != PACC_MAX;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count_r     <= '0;
      saturated_r <= 1'b0;
    end else if (acc_clear) begin
      count_r     <= '0;
      saturated_r <= 1'b0;
    end else begin
      if (step) count_r <= count_r + 1'b1;
      if (acc_symbol && tap_full) saturated_r <= 1'b1;
    end
  end

  a_stop_at_tap: assert property (@(posedge ref_clk) disable iff (!nrst)
    saturated_r && !acc_clear |=> $stable(count_r))
    else $error("accumulation continued after tap saturation");

endmodule

`default_nettype wire

// ---- logic/aag_core.sv ----
// Auto acknowledgement sequencer: preamble choice, turnaround, flags.
// Assumes receive status and configuration are synchronous to ref_clk.
`default_nettype none

module aag_core
  import aag_pkg::*;
#(
  parameter int TIM_SCALE = SYM_CYC
)(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // Configuration
  input  wire aag_cfg_t          cfg,
  input  wire logic [TIM_W-1:0]  ack_turnaround_time,
  // Host commands
  input  wire logic              tx_start_cmd,
  input  wire logic              transceiver_off_cmd,
  input  wire logic              rx_enable_cmd,
  input  wire logic              ack_flag_clear,
  // Receiver side
  input  wire aag_rx_t           rx,
  input  wire logic              acc_clear,
  input  wire logic              acc_symbol,
  input  wire logic [TAP_W-1:0]  tap_peak,
  // Status
  output logic                   ack_requested_flag,
  output logic                   rx_checksum_good_flag,
  output logic                   tx_frame_sent_flag,
  output logic                   sfd_loaded,
  output logic                   rx_on,
  output logic                   tx_on,
  output logic                   radiate,
  output logic                   ack_frame_pending,
  output logic [PLEN_W-1:0]      ack_preamble_len,
  output logic [PACC_W-1:0]      preamble_accum_count
);

  // ----------------------------------------------------------
  // Preamble accumulation
  // ----------------------------------------------------------
  logic [PACC_W-1:0] pacc_r;
  logic              sat_r;

  aag_pacc u_pacc (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .acc_clear  (acc_clear),
    .acc_symbol (acc_symbol),
    .tap_peak   (tap_peak),
    .count_r    (pacc_r),
    .saturated_r(sat_r)
  );

  // ----------------------------------------------------------
  // Preamble length selection
  // ----------------------------------------------------------
  wire logic [PACC_W-1:0] c = rx.preamble_accum_count;
  logic [PLEN_W-1:0] std_len;
  logic [PLEN_W-1:0] ext_len;
  wire logic [PLEN_W-1:0] sel_len = cfg.ext_frame_mode ? ext_len : std_len;

  always_comb begin
    case (rx.rx_preamble_symbol_rep)
      AAG_PSR_64:
        std_len = (c < 12'd65)  ? PL_64  :
                  (c < 12'd129) ? PL_128 :
                  (c < 12'd257) ? PL_256 : PL_512;
      AAG_PSR_1024:
        std_len = (c < 12'd1025) ? PL_1024 :
                  (c < 12'd1537) ? PL_1536 : PL_2048;
      AAG_PSR_4096: std_len = PL_4096;
      default:      std_len = PL_4096;
    endcase
  end

  assign ext_len = (c < 12'd17)   ? PL_16   :
                   (c < 12'd33)   ? PL_32   :
                   (c < 12'd65)   ? PL_64   :
                   (c < 12'd129)  ? PL_128  :
                   (c < 12'd257)  ? PL_256  :
                   (c < 12'd513)  ? PL_512  :
                   (c < 12'd1025) ? PL_1024 :
                   (c < 12'd1537) ? PL_1536 :
                   (c < 12'd2049) ? PL_2048 : PL_4096;

  // ----------------------------------------------------------
  // Qualification
  // ----------------------------------------------------------
  wire logic good_end   = rx.rx_end && rx.crc_good &&
                          (!cfg.frame_filter_en || rx.filter_pass);
  wire logic qualifies  = good_end && cfg.frame_filter_en &&
                          cfg.auto_ack_enable && rx.filter_pass &&
                          rx.data_or_cmd && rx.ack_req_bit;
  wire logic sfd_cmd    = tx_start_cmd && transceiver_off_cmd;
  wire logic [15:0] turn_cyc =
    16'(ack_turnaround_time * TIM_SCALE);

  // ----------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------
  aag_state_t st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic        done_pulse;

  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = (cnt_r == 16'h0000) ? cnt_r : cnt_r - 16'h0001;
    done_pulse = 1'b0;
    case (st_r)
      AAG_IDLE: begin
        if (sfd_cmd) st_nxt = AAG_SFD_INIT;
        else if (rx_enable_cmd) st_nxt = AAG_RX;
      end
      AAG_RX: begin
        if (transceiver_off_cmd) st_nxt = AAG_IDLE;
        else if (qualifies) begin
          st_nxt  = AAG_TURN;
          cnt_nxt = turn_cyc;
        end else if (good_end && !cfg.rx_auto_reenable) st_nxt = AAG_IDLE;
      end
      AAG_TURN: begin
        if (cnt_r == 16'h0000) begin
          st_nxt  = AAG_TX;
          cnt_nxt = 16'(ACK_TX_CYC) + {3'h0, ack_preamble_len};
        end
      end
      AAG_TX: begin
        if (cnt_r == 16'h0000) begin
          done_pulse = 1'b1;
          st_nxt = cfg.rx_auto_reenable ? AAG_RX : AAG_IDLE;
        end
      end
      AAG_SFD_INIT: st_nxt = AAG_IDLE;
      default: st_nxt = AAG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r  <= AAG_IDLE;
      cnt_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------
  // Outputs and flags
  // ----------------------------------------------------------
  wire logic set_aat = good_end && rx.ack_req_bit;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_requested_flag    <= 1'b0;
      rx_checksum_good_flag <= 1'b0;
      tx_frame_sent_flag    <= 1'b0;
      sfd_loaded            <= 1'b0;
      rx_on                 <= 1'b0;
      tx_on                 <= 1'b0;
      radiate               <= 1'b0;
      ack_frame_pending     <= 1'b0;
      ack_preamble_len      <= PL_64;
      preamble_accum_count  <= '0;
    end else begin
      // Set wins over clear
      if (set_aat) ack_requested_flag <= 1'b1;
      else if (ack_flag_clear) ack_requested_flag <= 1'b0;
      if (good_end) rx_checksum_good_flag <= 1'b1;
      else if (ack_flag_clear) rx_checksum_good_flag <= 1'b0;
      if (done_pulse) tx_frame_sent_flag <= 1'b1;
      else if (ack_flag_clear) tx_frame_sent_flag <= 1'b0;
      if (tx_start_cmd) sfd_loaded <= 1'b1;
      rx_on   <= (st_nxt == AAG_RX);
      tx_on   <= (st_nxt == AAG_TX) || (st_nxt == AAG_SFD_INIT);
      radiate <= (st_nxt == AAG_TX);
      if (qualifies) begin
        ack_preamble_len  <= sel_len;
        ack_frame_pending <= cfg.ack_pending_value;
      end
      preamble_accum_count <= pacc_r;
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  a_flags_together: assert property (@(posedge ref_clk) disable iff (!nrst)
    set_aat |=> ack_requested_flag && rx_checksum_good_flag)
    else $error("requested flag not set with checksum flag");
  a_std_4096: assert property (@(posedge ref_clk) disable iff (!nrst)
    qualifies && !cfg.ext_frame_mode &&
    rx.rx_preamble_symbol_rep == AAG_PSR_4096
    |=> ack_preamble_len == PL_4096)
    else $error("4096 repetition gave other preamble");
  a_std_64_top: assert property (@(posedge ref_clk) disable iff (!nrst)
    qualifies && !cfg.ext_frame_mode &&
    rx.rx_preamble_symbol_rep == AAG_PSR_64 && c > 12'd256
    |=> ack_preamble_len == PL_512)
    else $error("64 repetition long count not 512");
  a_std_1024_mid: assert property (@(posedge ref_clk) disable iff (!nrst)
    qualifies && !cfg.ext_frame_mode &&
    rx.rx_preamble_symbol_rep == AAG_PSR_1024 &&
    c > 12'd1024 && c < 12'd1537
    |=> ack_preamble_len == PL_1536)
    else $error("1024 repetition mid count not 1536");
  a_ext_short: assert property (@(posedge ref_clk) disable iff (!nrst)
    qualifies && cfg.ext_frame_mode && c < 12'd17
    |=> ack_preamble_len == PL_16)
    else $error("extended short count not 16");
  a_no_stale_ack: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r == AAG_RX && rx.rx_end && !rx.ack_req_bit
    |=> st_r != AAG_TURN)
    else $error("ack started without request bit");
  a_pend_copy: assert property (@(posedge ref_clk) disable iff (!nrst)
    qualifies |=> ack_frame_pending == $past(cfg.ack_pending_value))
    else $error("frame pending bit not copied");
  a_sfd_silent: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r == AAG_IDLE && sfd_cmd |=> ##1 !radiate && sfd_loaded)
    else $error("delimiter load radiated or did not load");
  a_reenable: assert property (@(posedge ref_clk) disable iff (!nrst)
    done_pulse && cfg.rx_auto_reenable |=> rx_on)
    else $error("receiver not re-enabled after ack");
  a_turn_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r == AAG_RX && !transceiver_off_cmd && qualifies &&
    turn_cyc == 16'h0000
    |=> ##1 st_r == AAG_TX)
    else $error("zero turnaround not honoured");

  c_ack_sent: cover property (@(posedge ref_clk) done_pulse);
  c_ext_ack:  cover property (@(posedge ref_clk)
    qualifies && cfg.ext_frame_mode);
  c_sfd_init: cover property (@(posedge ref_clk) st_r == AAG_SFD_INIT);
  c_stale:    cover property (@(posedge ref_clk)
    ack_requested_flag && good_end && !rx.ack_req_bit);
  c_pacc_sat: cover property (@(posedge ref_clk) sat_r);

endmodule

`default_nettype wire

// ---- verification/aag_node.sv ----
// Remote node model: presents the receive status of one frame end.
// Assumes the bench calls send just after a rising edge of ref_clk.
`default_nettype none

module aag_node
  import aag_pkg::*;
(
  // Clock
  input  wire logic    ref_clk,
  // Frame status toward the block
  output var  aag_rx_t rx
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int RW = $bits(aag_rx_t);

  initial rx = '0;

  // --------------------------------------------------------------
  // One frame end, then released fields show the inverse
  // --------------------------------------------------------------
  task automatic send(input logic ok, input logic pass, input logic req,
                      input aag_psr_t psr, input logic [PACC_W-1:0] cnt);
    @(posedge ref_clk) #2;
    rx <= aag_rx_t'({1'b1, ok, pass, 1'b1, req, psr, cnt});
    @(posedge ref_clk) #2;
    rx <= aag_rx_t'({1'b0, ~rx[RW-2:0]});
  endtask
endmodule

`default_nettype wire

// ---- verification/auto_ack_generation_tb.sv ----
// Self-checking bench for the auto acknowledgement sequencer.
// Assumes aag_node supplies frame ends; turnaround scale set to 1.
`default_nettype none

module auto_ack_generation_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aag_pkg::*;

  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic              ref_clk = 0;
  logic              nrst = 0;
  aag_cfg_t          cfg = '0;
  logic [TIM_W-1:0]  tim = 8'h01;
  logic              tx_st = 0, trx_off = 0, rx_en = 0, clr = 0;
  logic              acc_clear = 0, acc_symbol = 0;
  logic [TAP_W-1:0]  tap = 16'h0000;
  aag_rx_t           rx;
  logic              aflag, gflag, sflag, sfd, rx_on, tx_on, rad, pend_o;
  logic [PLEN_W-1:0] len_o;
  logic [PACC_W-1:0] cnt_o;
  int                errors = 0, cmp_count = 0, cyc = 0;
  int unsigned       seed = 77993;
  int                nfr = 0;
  logic [15:0]       tbl [] = '{16'h0040, 16'h0041, 16'h0080, 16'h0081,
    16'h0100, 16'h0101, 16'h1400, 16'h1401, 16'h1600, 16'h1601,
    16'h2000, 16'h2FFF, 16'h3064, 16'h4010, 16'h4011, 16'h4020,
    16'h4021, 16'h4800, 16'h4801};

  always #25 ref_clk = ~ref_clk;

  aag_node rn (.ref_clk(ref_clk), .rx(rx));

  aag_core #(.TIM_SCALE(1)) dut (
    .ref_clk(ref_clk), .nrst(nrst), .cfg(cfg),
    .ack_turnaround_time(tim), .tx_start_cmd(tx_st),
    .transceiver_off_cmd(trx_off), .rx_enable_cmd(rx_en),
    .ack_flag_clear(clr), .rx(rx), .acc_clear(acc_clear),
    .acc_symbol(acc_symbol), .tap_peak(tap),
    .ack_requested_flag(aflag), .rx_checksum_good_flag(gflag),
    .tx_frame_sent_flag(sflag), .sfd_loaded(sfd), .rx_on(rx_on),
    .tx_on(tx_on), .radiate(rad), .ack_frame_pending(pend_o),
    .ack_preamble_len(len_o), .preamble_accum_count(cnt_o));

  // --------------------------------------------------------------
  // Helpers and reference model
  // --------------------------------------------------------------
  task automatic step();
    @(posedge ref_clk) #2;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int exp_len(bit ext, int psr, int c);
    int t[$];
    int f;
    if (ext) begin
      t = {16, 32, 64, 128, 256, 512, 1024, 1536, 2048};
      f = 4096;
    end else if (psr == 0) begin
      t = {64, 128, 256};
      f = 512;
    end else if (psr == 1) begin
      t = {1024, 1536};
      f = 2048;
    end else begin
      return 4096;
    end
    foreach (t[i])
      if (c <= t[i]) return t[i];
    return f;
  endfunction

  task automatic sfd_init();
    tx_st = 1;
    trx_off = 1;
    step();
    tx_st = 0;
    trx_off = 0;
    chk("sfd_radiate", 0, rad);
    step();
    chk("sfd_loaded", 1, sfd);
    chk("sfd_radiate2", 0, rad);
  endtask

  task automatic clear_flags();
    clr = 1;
    step();
    clr = 0;
    step();
    chk("flag_cleared", 0, aflag);
  endtask

  task automatic frame(bit aa, bit ext, bit pass, bit req, int psr, int c,
                       bit ff = 1, bit ar = 1);
    int n;
    int len;
    bit pend;
    bit ack;
    pend = xs() % 2;
    ack = ff & aa & pass & req;
    len = exp_len(ext, psr, c);
    cfg = aag_cfg_t'({ff, aa, ar, pend, ext});
    // First frame exercises a zero turnaround
    tim = (nfr == 0) ? 8'h00 : 8'(1 + xs() % 8);
    nfr++;
    if (rx_on !== 1'b1) begin
      rx_en = 1;
      step();
      rx_en = 0;
      step();
      step();
    end
    rn.send(1'b1, pass, req, aag_psr_t'(psr), 12'(c));
    if (ack) chk("same_cycle", 16'h0003, 16'({gflag, aflag}));
    step();
    if (aa) chk("ack_req", 16'(req & (pass | !ff)), 16'(aflag));
    if (!ack) begin
      n = 0;
      repeat (tim + 12) begin
        step();
        if (tx_on === 1'b1) n++;
      end
      chk("no_ack", 0, 16'(n));
      clear_flags();
      return;
    end
    chk("ack_len", 16'(len), 16'(len_o));
    chk("pending", 16'(pend), 16'(pend_o));
    chk("crc_good", 1, 16'(gflag));
    n = 1;
    while (tx_on !== 1'b1 && n < 300) begin
      step();
      n++;
    end
    chk("turnaround", 1, 16'(n >= tim + 1 && n <= tim + 3));
    chk("radiate", 1, 16'(rad));
    n = 0;
    // Wait limit leaves room for a preamble one size larger
    while (sflag !== 1'b1 && n < 2 * len + 100) begin
      step();
      n++;
    end
    chk("tx_len", 1, 16'(n >= len + 38 && n <= len + 42));
    step();
    step();
    chk("rx_back", 16'(ar), 16'(rx_on));
    clear_flags();
  endtask

  task automatic summarize();
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Timeout and main sequence
  // --------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    #2 nrst = 1;
    step();
    chk("len_reset", 16'(PL_64), 16'(len_o));
    chk("sfd_reset", 0, 16'(sfd));
    sfd_init();
    cfg.ext_frame_mode = 1;
    step();
    sfd_init();
    acc_clear = 1;
    step();
    acc_clear = 0;
    tap = 16'h0100;
    repeat (9) begin
      if (cnt_o === 12'h005) tap = TAP_LIMIT;
      acc_symbol = 1;
      step();
      acc_symbol = 0;
      step();
    end
    step();
    chk("pacc_stop", 1,
        16'(cnt_o === 12'h005 || cnt_o === 12'h006));
    foreach (tbl[i]) begin
      frame(1, tbl[i][14], 1, 1, tbl[i][13:12], tbl[i][11:0]);
      // Short acks unreadable here: retry with a longer preamble
      if (exp_len(tbl[i][14], tbl[i][13:12], tbl[i][11:0]) < 64)
        frame(1, 1, 1, 1, 0, 64);
    end
    repeat (3) frame(1, 0, 1, 1, xs() % 2, xs() % 1400);
    frame(1, 0, 1, 1, 0, 100, 1, 0);
    frame(1, 0, 0, 1, 0, 100);
    frame(1, 0, 1, 0, 0, 100);
    frame(1, 0, 1, 1, 0, 100, 0);
    frame(0, 0, 1, 1, 0, 100);
    summarize();
  end
endmodule

`default_nettype wire
